/* File: rtl/timer_chan_ctrl.sv */
/*
 * host control bank of a 16-channel timer coprocessor: function select, host
 * sequence, host service request and priority fields, reached over apb.
 * assumes: apb master on pclk; the microengine pulses svc_done per channel when it
 * finishes a requested service; all inputs synchronous to pclk.
 */
// Implementation choices: the APB interface to the registers and the placing of the registers.
// What this block does
// - each channel picks one of 16 functions
// - per-channel sequence field selects function mode
// - engine completion clears service request to zero
// - priority decodes to disabled/4/2/1 of seven
// - high register channels 15-8, low 7-0
`timescale 1ns/1ps
`include "timer_chan_consts.svh"

module timer_chan_ctrl
    import timer_chan_pkg::*;
#(
    parameter int NUM_CHAN = 16,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // microengine side
    input wire logic [NUM_CHAN-1:0] svc_done,
    output logic [4*NUM_CHAN-1:0] func_sel,
    output logic [2*NUM_CHAN-1:0] seq_mode,
    output logic [2*NUM_CHAN-1:0] svc_req,
    output logic [2*NUM_CHAN-1:0] prio_field,
    output logic [NUM_CHAN-1:0] chan_enable,
    output logic [3*NUM_CHAN-1:0] slot_share
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // register packing is fixed at two words of eight channels, four words of four for function select
    if (NUM_CHAN != 16) begin : g_bad_chan
        $error("timer_chan_ctrl supports exactly 16 channels");
    end
    if (ADDR_W < 8) begin : g_bad_addr
        $error("timer_chan_ctrl needs at least 8 address bits");
    end

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [63:0] fsel_r; // channel c at bits 4c+3:4c
    logic [31:0] seq_r; // channel c at bits 2c+1:2c
    logic [31:0] svc_r;
    logic [31:0] prio_r;
    logic [31:0] svc_nxt;
    logic [31:0] prdata_r;
    logic pslverr_r;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    wire [ADDR_W-3:0] idx = paddr[ADDR_W-1:2];
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_f0 = aligned && (idx == (ADDR_W-2)'(`FSEL0_IDX));
    wire hit_f1 = aligned && (idx == (ADDR_W-2)'(`FSEL1_IDX));
    wire hit_f2 = aligned && (idx == (ADDR_W-2)'(`FSEL2_IDX));
    wire hit_f3 = aligned && (idx == (ADDR_W-2)'(`FSEL3_IDX));
    wire hit_sh = aligned && (idx == (ADDR_W-2)'(`SEQ_HI_IDX));
    wire hit_sl = aligned && (idx == (ADDR_W-2)'(`SEQ_LO_IDX));
    wire hit_vh = aligned && (idx == (ADDR_W-2)'(`SVC_HI_IDX));
    wire hit_vl = aligned && (idx == (ADDR_W-2)'(`SVC_LO_IDX));
    wire hit_ph = aligned && (idx == (ADDR_W-2)'(`PRIO_HI_IDX));
    wire hit_pl = aligned && (idx == (ADDR_W-2)'(`PRIO_LO_IDX));
    wire hit_any = hit_f0 | hit_f1 | hit_f2 | hit_f3 | hit_sh | hit_sl
                 | hit_vh | hit_vl | hit_ph | hit_pl;

    // setup phase samples the read data; zero-wait access follows
    wire setup_ph = psel && !penable;
    wire wr_en = psel && penable && pwrite && hit_any;
    // byte lanes: only the low two carry register bits
    wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [15:0] wdat = pwdata[15:0];

    // read mux, unmapped reads zero
    wire [15:0] rd_word =
        hit_f0 ? fsel_r[63:48] : hit_f1 ? fsel_r[47:32] :
        hit_f2 ? fsel_r[31:16] : hit_f3 ? fsel_r[15:0] :
        hit_sh ? seq_r[31:16] : hit_sl ? seq_r[15:0] :
        hit_vh ? svc_r[31:16] : hit_vl ? svc_r[15:0] :
        hit_ph ? prio_r[31:16] : hit_pl ? prio_r[15:0] : 16'h0000;

    // merge helper for masked word writes
    function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [15:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    // ----------------------------------------
    // host-writable configuration fields
    // ----------------------------------------
    // function, sequence and priority words change only on host writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsel_r <= {4{`REG_RESET}};
            seq_r <= {2{`REG_RESET}};
            prio_r <= {2{`REG_RESET}};
        end else if (wr_en) begin
            if (hit_f0) fsel_r[63:48] <= merge(fsel_r[63:48], wdat, wmask);
            if (hit_f1) fsel_r[47:32] <= merge(fsel_r[47:32], wdat, wmask);
            if (hit_f2) fsel_r[31:16] <= merge(fsel_r[31:16], wdat, wmask);
            if (hit_f3) fsel_r[15:0] <= merge(fsel_r[15:0], wdat, wmask);
            if (hit_sh) seq_r[31:16] <= merge(seq_r[31:16], wdat, wmask);
            if (hit_sl) seq_r[15:0] <= merge(seq_r[15:0], wdat, wmask);
            if (hit_ph) prio_r[31:16] <= merge(prio_r[31:16], wdat, wmask);
            if (hit_pl) prio_r[15:0] <= merge(prio_r[15:0], wdat, wmask);
        end
    end

    // ----------------------------------------
    // service request handshake, per channel
    // ----------------------------------------
    // a host write to a field beats a completion in the same cycle, so a fresh
    // request is never lost to the clear of the previous one
    for (genvar c = 0; c < NUM_CHAN; c++) begin : g_svc
        localparam int B = (2 * c) % 16;
        wire wr_hit = wr_en && ((c >= 8) ? hit_vh : hit_vl);
        wire lane_on = wmask[B];
        logic [1:0] field_nxt; // this channel's next service field
        always_comb begin
            if (wr_hit && lane_on) begin
                field_nxt = wdat[B+1:B];
            end else if (svc_done[c]) begin
                field_nxt = 2'b00;
            end else begin
                field_nxt = svc_r[2*c+1:2*c];
            end
        end
        // one continuous assignment per slice, so no two processes share svc_nxt
        assign svc_nxt[2*c+1:2*c] = field_nxt;
        // per-channel priority decode
        prio_slot_decode u_prio (
            .prio_field(prio_r[2*c+1:2*c]),
            .chan_enable(chan_enable[c]),
            .slot_share(slot_share[3*c+2:3*c])
        );
    end

    // service words register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            svc_r <= {2{`REG_RESET}};
        end else begin
            svc_r <= svc_nxt;
        end
    end

    // ----------------------------------------
    // apb answer
    // ----------------------------------------
    // read data and error are taken in setup, so access needs no wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
            pslverr_r <= !hit_any; // unmapped or misaligned
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r;
    assign pready = 1'b1;
    assign func_sel = fsel_r;
    assign seq_mode = seq_r;
    assign svc_req = svc_r;
    assign prio_field = prio_r;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_fsel_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_f3 && pstrb[0]) |=> (func_sel[3:0] == $past(pwdata[3:0]));
    endproperty
    a_fsel_write: assert property (p_fsel_write) else $error("function select not stored");

    property p_seq_hi_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && hit_sh && pstrb[1:0] == 2'b11) |=> (seq_mode[31:30] == $past(pwdata[15:14]));
    endproperty
    a_seq_hi_write: assert property (p_seq_hi_write) else $error("channel 15 sequence wrong");

    property p_done_clear;
        @(posedge pclk) disable iff (!presetn)
        (svc_done[7] && !(wr_en && hit_vl)) |=> (svc_req[15:14] == 2'b00);
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("completion did not clear");

    property p_svc_hold;
        @(posedge pclk) disable iff (!presetn)
        (!svc_done[7] && !(wr_en && hit_vl)) |=> $stable(svc_req[15:14]);
    endproperty
    a_svc_hold: assert property (p_svc_hold) else $error("service field changed alone");

    property p_prio_low;
        @(posedge pclk) disable iff (!presetn)
        (prio_field[1:0] == 2'b01) |-> (slot_share[2:0] == 3'd4 && chan_enable[0]);
    endproperty
    a_prio_low: assert property (p_prio_low) else $error("low priority share wrong");

    property p_prio_off;
        @(posedge pclk) disable iff (!presetn)
        (prio_field[31:30] == 2'b00) |-> (!chan_enable[15] && slot_share[47:45] == 3'd0);
    endproperty
    a_prio_off: assert property (p_prio_off) else $error("disabled channel enabled");

    property p_svc_hi_read;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && hit_vh) ##1 (psel && penable)
            |-> (prdata[15:0] == $past(svc_req[31:16]) && !pslverr);
    endproperty
    a_svc_hi_read: assert property (p_svc_hi_read) else $error("high word read mismatch");

    property p_prio_lo_read;
        @(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && hit_pl) |=> (prdata == {16'h0000, $past(prio_field[15:0])});
    endproperty
    a_prio_lo_read: assert property (p_prio_lo_read) else $error("priority read mismatch");

    c_request: cover property (@(posedge pclk) disable iff (!presetn)
        (svc_req[15:14] != 2'b00) ##[1:20] (svc_req[15:14] == 2'b00));
    c_collide: cover property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_vl && svc_done[0]));
    c_high_prio: cover property (@(posedge pclk) disable iff (!presetn)
        (prio_field[31:30] == 2'b11));
    c_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pslverr));
endmodule

/* File: include/timer_chan_consts.svh */
/*
 * register indices, field layout, reset values and guaranteed slot shares of the timer channel
 * host control bank.
 * assumes: included by bare name; byte address of a register is four times its index.
 */
`ifndef TIMER_CHAN_CONSTS_SVH
`define TIMER_CHAN_CONSTS_SVH

// ----------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------
`define FSEL0_IDX 6'h0c
`define FSEL1_IDX 6'h0e
`define FSEL2_IDX 6'h10
`define FSEL3_IDX 6'h12
`define SEQ_HI_IDX 6'h14
`define SEQ_LO_IDX 6'h16
`define SVC_HI_IDX 6'h18
`define SVC_LO_IDX 6'h1a
`define PRIO_HI_IDX 6'h1c
`define PRIO_LO_IDX 6'h1e

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define FSEL_W 4
`define PAIR_W 2
`define REG_W 16
`define REG_RESET 16'h0000

// ----------------------------------------
// guaranteed slots out of seven per level
// ----------------------------------------
`define SLOTS_LOW 3'h4
`define SLOTS_MID 3'h2
`define SLOTS_HIGH 3'h1
`define SLOTS_NONE 3'h0

`endif

/* File: include/timer_chan_pkg.sv */
/*
 * types shared by the timer channel host control bank.
 * assumes: compiled before any module that imports it.
 */
package timer_chan_pkg;
    // priority levels, in field encoding order 00..11
    typedef enum logic [1:0] {
        PRIO_DISABLED,
        PRIO_LOW,
        PRIO_MID,
        PRIO_HIGH
    } prio_level_t;
endpackage

/* File: rtl/prio_slot_decode.sv */
/*
 * decodes one channel's 2-bit priority field into enable and guaranteed slot share.
 * assumes: purely combinational, used once per channel by the control bank.
 */
`timescale 1ns/1ps
`include "timer_chan_consts.svh"

module prio_slot_decode
    import timer_chan_pkg::*;
(
    // priority field in
    input wire logic [1:0] prio_field,
    // decoded result
    output logic chan_enable,
    output logic [2:0] slot_share
);
    // ----------------------------------------
    // level decode
    // ----------------------------------------
    prio_level_t level;
    assign level = prio_level_t'(prio_field);
    assign chan_enable = (level != PRIO_DISABLED);

    // slots out of seven: low gets most, high fewest but soonest
    always_comb begin
        case (level)
            PRIO_LOW: slot_share = `SLOTS_LOW;
            PRIO_MID: slot_share = `SLOTS_MID;
            PRIO_HIGH: slot_share = `SLOTS_HIGH;
            default: slot_share = `SLOTS_NONE; // disabled, no service
        endcase
    end
endmodule

/* File: testbench/engine_model.sv */
/*
 * microengine stand-in: finishes every pending host service request after a delay.
 * assumes: same pclk/presetn as the control bank; delay is set by the bench.
 */
`timescale 1ns/1ps

module engine_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control bank side
    input wire logic [31:0] svc_req,
    input wire logic [7:0] delay,
    output logic [15:0] svc_done
);
    logic [7:0] wait_r; // cycles spent on the pending work
    logic [15:0] pend; // channels holding a nonzero request

    // a nonzero two-bit code marks a live request
    always_comb begin
        for (int c = 0; c < 16; c++) begin
            pend[c] = |svc_req[2*c +: 2];
        end
    end

    // one-cycle done pulse per batch; gap after it lets the clear land first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 8'h00;
            svc_done <= 16'h0000;
        end else if (svc_done != 16'h0000 || pend == 16'h0000) begin
            wait_r <= 8'h00;
            svc_done <= 16'h0000;
        end else if (wait_r >= delay) begin
            wait_r <= 8'h00;
            svc_done <= pend;
        end else begin
            wait_r <= wait_r + 8'h01;
        end
    end
endmodule

/* File: testbench/timer_chan_ctrl_tb.sv */
/*
 * self-checking bench of the timer channel host control bank.
 * assumes: zero-wait apb slave; engine_model plays the microengine.
 */
`timescale 1ns/1ps
`include "timer_chan_consts.svh"

module timer_chan_ctrl_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exp_on;
    logic [7:0] paddr, dly, amap[8];
    logic [31:0] pwdata, prdata, rd, seed, seq_mode, svc_req, prio_field;
    logic [3:0] pstrb;
    logic [15:0] svc_done, chan_enable, sh[8];
    logic [63:0] func_sel;
    logic [47:0] slot_share;
    logic [32:0] expq[$]; // {error, read data} notes
    logic [32:0] e_m;
    logic [2:0] sl[4];
    logic [1:0] pf; // one channel's priority field, from the bench's own copy
    int fail_count, comparisons, n;

    timer_chan_ctrl #(.NUM_CHAN(16), .ADDR_W(8)) timer_chan_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .svc_done(svc_done),
        .func_sel(func_sel), .seq_mode(seq_mode), .svc_req(svc_req),
        .prio_field(prio_field), .chan_enable(chan_enable), .slot_share(slot_share));

    engine_model engine_model_inst (.pclk(pclk), .presetn(presetn),
        .svc_req(svc_req), .delay(dly), .svc_done(svc_done));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task report_and_stop;
        $display("counts: %0d compared, %0d mismatched", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input logic [63:0] got, input logic [63:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // one apb transfer; e notes an expected read result for the monitor
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic e, input logic [15:0] ev, input logic ee);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        exp_on <= e;
        if (e) expq.push_back({ee, 16'h0000, ev});
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: no ready", $time);
            report_and_stop();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        exp_on <= 1'b0;
    endtask

    // monitor: compares each noted read at its access edge
    always @(posedge pclk) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
            && exp_on === 1'b1) begin
            e_m = expq.pop_front();
            chk({31'h0, pslverr, prdata}, {31'h0, e_m}, "read data or error");
        end
    end

    initial begin
        #200000;
        fail_count++;
        $display("mismatch at %0t: run limit", $time);
        report_and_stop();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; pstrb = 4'hf; exp_on = 1'b0; dly = 8'h01; seed = 32'd95375;
        fail_count = 0; comparisons = 0;
        amap = '{{`FSEL0_IDX, 2'b00}, {`FSEL1_IDX, 2'b00}, {`FSEL2_IDX, 2'b00},
                 {`FSEL3_IDX, 2'b00}, {`SEQ_HI_IDX, 2'b00}, {`SEQ_LO_IDX, 2'b00},
                 {`PRIO_HI_IDX, 2'b00}, {`PRIO_LO_IDX, 2'b00}};
        sl = '{3'h0, 3'h4, 3'h2, 3'h1};
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values of every register except the low service word
        for (int i = 0; i < 8; i++) apb(1'b0, amap[i], 0, 1'b1, 16'h0000, 1'b0);
        apb(1'b0, {`SVC_HI_IDX, 2'b00}, 0, 1'b1, 16'h0000, 1'b0);
        chk(slot_share, 0, "slot share after reset");
        $display("test reset values done");
        // random fields, readback and packing onto channel outputs
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            sh[i] = seed[15:0];
            apb(1'b1, amap[i], seed, 1'b0, 16'h0000, 1'b0);
        end
        for (int i = 0; i < 8; i++) apb(1'b0, amap[i], 0, 1'b1, sh[i], 1'b0);
        @(negedge pclk);
        chk(func_sel, {sh[0], sh[1], sh[2], sh[3]}, "function fields");
        chk(seq_mode, {sh[4], sh[5]}, "sequence fields");
        chk(prio_field, {sh[6], sh[7]}, "priority fields");
        for (int ch = 0; ch < 16; ch++) begin
            pf = sh[(ch < 8) ? 7 : 6][2*(ch%8) +: 2];
            chk(chan_enable[ch], pf != 2'b00, "enable per channel");
            chk(slot_share[3*ch +: 3], sl[pf], "share per channel");
        end
        $display("test field packing done");
        // every priority code on channels 7..0
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, amap[7], {16'h0000, {8{p[1:0]}}}, 1'b0, 16'h0000, 1'b0);
            @(negedge pclk);
            chk(chan_enable[7:0], {8{p != 0}}, "channel enable");
            chk(slot_share[23:0], {8{sl[p]}}, "slot share");
        end
        $display("test priority decode done");
        // every request code, prompt then slow engine, host polls for zero
        for (int s = 0; s < 2; s++) begin
            dly <= (s == 0) ? 8'h01 : 8'h28;
            for (int c = 1; c < 4; c++) begin
                apb(1'b1, {`SVC_LO_IDX, 2'b00}, {16'h0000, c[1:0], 14'h0000}, 1'b0, 0, 1'b0);
                @(negedge pclk);
                if (s == 1) chk(svc_req[15:14], c, "request held");
                n = 0;
                do begin
                    apb(1'b0, {`SVC_LO_IDX, 2'b00}, 0, 1'b0, 0, 1'b0);
                    n++;
                end while (rd[15:0] !== 16'h0000 && n < 30);
                if (rd[15:0] !== 16'h0000) begin
                    fail_count++;
                    $display("mismatch at %0t: poll limit", $time);
                    report_and_stop();
                end
                apb(1'b0, {`SVC_LO_IDX, 2'b00}, 0, 1'b1, 16'h0000, 1'b0);
                chk(svc_req, 0, "request cleared");
            end
        end
        $display("test service handshake done");
        // unmapped and misaligned accesses are refused
        apb(1'b1, 8'h04, 32'hffff, 1'b0, 0, 1'b0);
        apb(1'b0, 8'h04, 0, 1'b1, 16'h0000, 1'b1);
        apb(1'b1, {`SEQ_HI_IDX, 2'b01}, 32'h1234, 1'b0, 0, 1'b0);
        // only the low byte lane is enabled: the high byte keeps its value
        pstrb <= 4'h1;
        apb(1'b1, {`SEQ_LO_IDX, 2'b00}, 32'hffff, 1'b0, 0, 1'b0);
        pstrb <= 4'hf;
        apb(1'b0, {`SEQ_LO_IDX, 2'b00}, 0, 1'b1, {sh[5][15:8], 8'hff}, 1'b0);
        apb(1'b0, {`SEQ_HI_IDX, 2'b00}, 0, 1'b1, sh[4], 1'b0);
        $display("test refused access done");
        repeat (2) @(posedge pclk);
        report_and_stop();
    end
endmodule
